// ---- common/lslc_defines.svh ----
`ifndef LSLC_DEFINES_SVH
`define LSLC_DEFINES_SVH

// Management register addresses
`define LSLC_ADDR_PLL_SEL   5'h06
`define LSLC_ADDR_DRIVE     5'h07
`define LSLC_ADDR_ERR_CNT   5'h10
`define LSLC_ADDR_LOS_CNT   5'h11
`define LSLC_ADDR_STATUS    5'h12

// Reset values
`define LSLC_RST_PLL_SEL    16'h8115
`define LSLC_RST_DRIVE      16'hdd05

// Reset values of the output flops, one field copy per lane where per lane
`define LSLC_RST_BW         2'h1
`define LSLC_RST_MPY        4'h5
`define LSLC_RST_SWING_ALL  24'hb6_db6d
`define LSLC_RST_LOS_ALL    8'hff
`define LSLC_RST_RATE_ALL   16'h5555
`define LSLC_RST_DE_ALL     32'h0000_0000

// Fields of low_side_pll_lane_select
`define LSLC_BCAST_BIT      15
`define LSLC_SEL_HI         14
`define LSLC_SEL_LO         12
`define LSLC_BW_HI          9
`define LSLC_BW_LO          8
`define LSLC_PLL_ON_BIT     4
`define LSLC_MPY_HI         3
`define LSLC_MPY_LO         0

// Fields of low_side_lane_drive_control
`define LSLC_SWING_HI       14
`define LSLC_SWING_LO       12
`define LSLC_LOS_BIT        11
`define LSLC_TXON_BIT       10
`define LSLC_TXRATE_HI      9
`define LSLC_TXRATE_LO      8
`define LSLC_DE_HI          7
`define LSLC_DE_LO          4
`define LSLC_RXON_BIT       2
`define LSLC_RXRATE_HI      1
`define LSLC_RXRATE_LO      0

// Management frame framing
`define LSLC_LANES          8
`define LSLC_PRE_LEN        6'h20
`define LSLC_HDR_LAST       6'h0c
`define LSLC_TA_LAST        6'h01
`define LSLC_DATA_LAST      6'h0f
`define LSLC_OP_READ        2'h2
`define LSLC_OP_WRITE       2'h1
`define LSLC_HDR_ST_BIT     12
`define LSLC_HDR_OP_HI      11
`define LSLC_HDR_OP_LO      10
`define LSLC_HDR_PHY_HI     9
`define LSLC_HDR_PHY_LO     5
`define LSLC_HDR_REG_HI     4
`define LSLC_HDR_REG_LO     0

`endif

// ---- common/lslc_pkg.sv ----
package lslc_pkg;
   // Frame states, Gray coded along preamble -> header -> turnaround -> data
   typedef enum logic [1:0] {
      LSLC_PRE  = 2'h0,
      LSLC_HDR  = 2'h1,
      LSLC_TA   = 2'h3,
      LSLC_DATA = 2'h2
   } lslc_state_e;
   typedef logic [2:0]  lslc_lane_t;
   typedef logic [15:0] lslc_word_t;
endpackage

// ---- core/lslc_core.sv ----
`timescale 1ns/1ps
`include "lslc_defines.svh"

module lslc_core #(
   parameter logic [4:0] PHY_ADDR = 5'h00
) (
   input  wire logic                     clk_in,
   input  wire logic                     sys_rst_in,
   input  wire logic                     mdc_in,
   input  wire logic                     mdio_in,
   output logic                          mdio_out,
   output logic                          mdio_oe_out,
   input  wire logic                     channel_powerdown_n_in,
   input  wire logic                     global_powerdown_in,
   input  wire logic [127:0]             lane_error_counter_in,
   input  wire logic [127:0]             lane_signal_loss_count_in,
   input  wire logic [127:0]             lane_status_word_in,
   output logic                          low_side_pll_on_out,
   output logic [1:0]                    pll_loop_bw_out,
   output logic [3:0]                    pll_multiplier_out,
   output logic [23:0]                   output_swing_out,
   output logic [7:0]                    signal_loss_detect_en_out,
   output logic [7:0]                    tx_lane_on_out,
   output logic [15:0]                   tx_lane_speed_out,
   output logic [31:0]                   deemphasis_level_out,
   output logic [7:0]                    rx_lane_on_out,
   output logic [15:0]                   rx_lane_speed_out
);
   import lslc_pkg::*;

   // Pin filter: accept a new level only once the 2nd and 3rd stages agree
   function automatic logic filt(input logic s2, input logic s3, input logic prev);
      filt = (s2 == s3) ? s2 : prev;
   endfunction

   logic [2:0]  mdc_sync_q,  mdc_sync_d;
   logic [2:0]  mdio_sync_q, mdio_sync_d;
   logic [2:0]  pdn_sync_q,  pdn_sync_d;
   logic        mdc_f_q,     mdc_f_d;
   logic        mdio_f_q,    mdio_f_d;
   logic        pdn_f_q,     pdn_f_d;

   // Input synchronisers and agreement filters
   always_comb begin
      mdc_sync_d  = {mdc_sync_q[1:0], mdc_in};
      mdio_sync_d = {mdio_sync_q[1:0], mdio_in};
      pdn_sync_d  = {pdn_sync_q[1:0], channel_powerdown_n_in};
      mdc_f_d     = filt(mdc_sync_q[1], mdc_sync_q[2], mdc_f_q);
      mdio_f_d    = filt(mdio_sync_q[1], mdio_sync_q[2], mdio_f_q);
      pdn_f_d     = filt(pdn_sync_q[1], pdn_sync_q[2], pdn_f_q);
   end

   // Powerdown level starts low so lanes stay off until the pin is seen high
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mdc_sync_q  <= 3'h7;
         mdio_sync_q <= 3'h7;
         pdn_sync_q  <= 3'h0;
         mdc_f_q     <= 1'b1;
         mdio_f_q    <= 1'b1;
         pdn_f_q     <= 1'b0;
      end else begin
         mdc_sync_q  <= mdc_sync_d;
         mdio_sync_q <= mdio_sync_d;
         pdn_sync_q  <= pdn_sync_d;
         mdc_f_q     <= mdc_f_d;
         mdio_f_q    <= mdio_f_d;
         pdn_f_q     <= pdn_f_d;
      end
   end

   lslc_state_e state_q, state_d;
   logic [5:0]  cnt_q,   cnt_d;
   logic [12:0] hdr_q,   hdr_d;
   lslc_word_t  shift_q, shift_d;
   logic        out_q,   out_d;
   logic        oe_q,    oe_d;
   logic        rd_q,    rd_d;
   logic        wr_q,    wr_d;
   lslc_word_t  pll_sel_q, pll_sel_d;
   lslc_word_t  drive_q [0:7];
   lslc_word_t  drive_d [0:7];

   logic        mdc_rise;
   logic        hit;
   lslc_lane_t  lane_sel;
   logic [6:0]  lane_base;
   lslc_word_t  rword;
   lslc_word_t  wword;

   // Frame decoder, register file and read mux
   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      hdr_d     = hdr_q;
      shift_d   = shift_q;
      out_d     = out_q;
      oe_d      = oe_q;
      rd_d      = rd_q;
      wr_d      = wr_q;
      pll_sel_d = pll_sel_q;
      for (int i = 0; i < `LSLC_LANES; i++) begin
         drive_d[i] = drive_q[i];
      end
      // Host samples on the rising edge, so we act right after each one
      mdc_rise  = mdc_f_d & ~mdc_f_q;
      lane_sel  = pll_sel_q[`LSLC_SEL_HI:`LSLC_SEL_LO];
      lane_base = {lane_sel, 4'h0};
      hit       = hdr_q[`LSLC_HDR_ST_BIT] &&
                  (hdr_q[`LSLC_HDR_PHY_HI:`LSLC_HDR_PHY_LO] == PHY_ADDR);
      wword     = {shift_q[14:0], mdio_f_d};
      case (hdr_q[`LSLC_HDR_REG_HI:`LSLC_HDR_REG_LO])
         `LSLC_ADDR_PLL_SEL: rword = pll_sel_q;
         `LSLC_ADDR_DRIVE:   rword = drive_q[lane_sel];
         `LSLC_ADDR_ERR_CNT: rword = lane_error_counter_in[lane_base +: 16];
         `LSLC_ADDR_LOS_CNT: rword = lane_signal_loss_count_in[lane_base +: 16];
         `LSLC_ADDR_STATUS:  rword = lane_status_word_in[lane_base +: 16];
         default:            rword = 16'h0000;
      endcase
      if (mdc_rise) begin
         case (state_q)
            LSLC_PRE: begin
               if (mdio_f_d) begin
                  cnt_d = (cnt_q == `LSLC_PRE_LEN) ? cnt_q : cnt_q + 6'h01;
               end else if (cnt_q == `LSLC_PRE_LEN) begin
                  state_d = LSLC_HDR;
                  cnt_d   = 6'h00;
               end else begin
                  cnt_d = 6'h00;
               end
            end
            LSLC_HDR: begin
               hdr_d = {hdr_q[11:0], mdio_f_d};
               if (cnt_q == `LSLC_HDR_LAST) begin
                  state_d = LSLC_TA;
                  cnt_d   = 6'h00;
               end else begin
                  cnt_d = cnt_q + 6'h01;
               end
            end
            LSLC_TA: begin
               if (cnt_q != `LSLC_TA_LAST) begin
                  cnt_d = `LSLC_TA_LAST;
                  rd_d  = hit && (hdr_q[`LSLC_HDR_OP_HI:`LSLC_HDR_OP_LO] == `LSLC_OP_READ);
                  wr_d  = hit && (hdr_q[`LSLC_HDR_OP_HI:`LSLC_HDR_OP_LO] == `LSLC_OP_WRITE);
                  oe_d  = rd_d; // Drive the turnaround zero on reads only
                  out_d = 1'b0;
               end else begin
                  state_d = LSLC_DATA;
                  cnt_d   = 6'h00;
                  if (rd_q) begin
                     out_d   = rword[15];
                     shift_d = {rword[14:0], 1'b0};
                  end
               end
            end
            LSLC_DATA: begin
               if (rd_q) begin
                  out_d   = shift_q[15];
                  shift_d = {shift_q[14:0], 1'b0};
               end else begin
                  shift_d = wword;
               end
               if (cnt_q == `LSLC_DATA_LAST) begin
                  if (wr_q) begin
                     if (hdr_q[`LSLC_HDR_REG_HI:`LSLC_HDR_REG_LO] == `LSLC_ADDR_PLL_SEL) begin
                        pll_sel_d = wword;
                     end
                     if (hdr_q[`LSLC_HDR_REG_HI:`LSLC_HDR_REG_LO] == `LSLC_ADDR_DRIVE) begin
                        for (int i = 0; i < `LSLC_LANES; i++) begin
                           if (pll_sel_q[`LSLC_BCAST_BIT]) begin
                              drive_d[i] = wword;
                           end else if (3'(i) == lane_sel) begin
                              drive_d[i] = wword;
                           end
                        end
                     end
                  end
                  state_d = LSLC_PRE;
                  cnt_d   = 6'h00;
                  oe_d    = 1'b0;
                  out_d   = 1'b0;
                  rd_d    = 1'b0;
                  wr_d    = 1'b0;
               end else begin
                  cnt_d = cnt_q + 6'h01;
               end
            end
            default: begin
               state_d = LSLC_PRE;
               cnt_d   = 6'h00;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // A fresh preamble is needed for every frame; reset values set all fields
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q   <= LSLC_PRE;
         cnt_q     <= 6'h00;
         hdr_q     <= 13'h0000;
         shift_q   <= 16'h0000;
         out_q     <= 1'b0;
         oe_q      <= 1'b0;
         rd_q      <= 1'b0;
         wr_q      <= 1'b0;
         pll_sel_q <= `LSLC_RST_PLL_SEL;
         for (int i = 0; i < `LSLC_LANES; i++) begin
            drive_q[i] <= `LSLC_RST_DRIVE;
         end
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         hdr_q     <= hdr_d;
         shift_q   <= shift_d;
         out_q     <= out_d;
         oe_q      <= oe_d;
         rd_q      <= rd_d;
         wr_q      <= wr_d;
         pll_sel_q <= pll_sel_d;
         for (int i = 0; i < `LSLC_LANES; i++) begin
            drive_q[i] <= drive_d[i];
         end
      end
   end

   logic        pd;
   logic        pll_on_d;
   logic [1:0]  bw_d;
   logic [3:0]  mpy_d;
   logic [23:0] swing_d;
   logic [7:0]  los_d;
   logic [7:0]  txon_d;
   logic [15:0] txrate_d;
   logic [31:0] de_d;
   logic [7:0]  rxon_d;
   logic [15:0] rxrate_d;

   // Analog controls; powerdown overrides the PLL and lane on enables, one cycle after global_powerdown_in and five cycles after the powerdown pin
   always_comb begin
      pd       = ~pdn_f_q | global_powerdown_in;
      pll_on_d = pll_sel_q[`LSLC_PLL_ON_BIT] & ~pd;
      bw_d     = pll_sel_q[`LSLC_BW_HI:`LSLC_BW_LO];
      mpy_d    = pll_sel_q[`LSLC_MPY_HI:`LSLC_MPY_LO];
      swing_d  = 24'h00_0000;
      los_d    = 8'h00;
      txon_d   = 8'h00;
      txrate_d = 16'h0000;
      de_d     = 32'h0000_0000;
      rxon_d   = 8'h00;
      rxrate_d = 16'h0000;
      for (int i = 0; i < `LSLC_LANES; i++) begin
         swing_d[i*3 +: 3]  = drive_q[i][`LSLC_SWING_HI:`LSLC_SWING_LO];
         los_d[i]           = drive_q[i][`LSLC_LOS_BIT];
         txon_d[i]          = drive_q[i][`LSLC_TXON_BIT] & ~pd;
         txrate_d[i*2 +: 2] = drive_q[i][`LSLC_TXRATE_HI:`LSLC_TXRATE_LO];
         de_d[i*4 +: 4]     = drive_q[i][`LSLC_DE_HI:`LSLC_DE_LO];
         rxon_d[i]          = drive_q[i][`LSLC_RXON_BIT] & ~pd;
         rxrate_d[i*2 +: 2] = drive_q[i][`LSLC_RXRATE_HI:`LSLC_RXRATE_LO];
      end
   end

   // Output flops; PLL and lane on enables start off because the powerdown level starts low
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         low_side_pll_on_out       <= 1'b0;
         pll_loop_bw_out           <= `LSLC_RST_BW;
         pll_multiplier_out        <= `LSLC_RST_MPY;
         output_swing_out          <= `LSLC_RST_SWING_ALL;
         signal_loss_detect_en_out <= `LSLC_RST_LOS_ALL;
         tx_lane_on_out            <= 8'h00;
         tx_lane_speed_out         <= `LSLC_RST_RATE_ALL;
         deemphasis_level_out      <= `LSLC_RST_DE_ALL;
         rx_lane_on_out            <= 8'h00;
         rx_lane_speed_out         <= `LSLC_RST_RATE_ALL;
      end else begin
         low_side_pll_on_out       <= pll_on_d;
         pll_loop_bw_out           <= bw_d;
         pll_multiplier_out        <= mpy_d;
         output_swing_out          <= swing_d;
         signal_loss_detect_en_out <= los_d;
         tx_lane_on_out            <= txon_d;
         tx_lane_speed_out         <= txrate_d;
         deemphasis_level_out      <= de_d;
         rx_lane_on_out            <= rxon_d;
         rx_lane_speed_out         <= rxrate_d;
      end
   end

   assign mdio_out    = out_q;
   assign mdio_oe_out = oe_q;

endmodule

// ---- sim/lslc_core_sva.sv ----
`timescale 1ns/1ps
module lslc_core_sva (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        mdc_in,
   input wire logic        mdio_out,
   input wire logic        mdio_oe_out,
   input wire logic        channel_powerdown_n_in,
   input wire logic        global_powerdown_in,
   input wire logic        low_side_pll_on_out,
   input wire logic [1:0]  pll_loop_bw_out,
   input wire logic [3:0]  pll_multiplier_out,
   input wire logic [23:0] output_swing_out,
   input wire logic [7:0]  signal_loss_detect_en_out,
   input wire logic [7:0]  tx_lane_on_out,
   input wire logic [15:0] tx_lane_speed_out,
   input wire logic [31:0] deemphasis_level_out,
   input wire logic [7:0]  rx_lane_on_out,
   input wire logic [15:0] rx_lane_speed_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [3:0] pd_cnt_q, pd_cnt_d;
   logic [5:0] idle_cnt_q, idle_cnt_d;
   logic       mdc_q, mdc_d;
   // Saturating run lengths of powerdown and of a quiet MDC, so they stay small
   always_comb begin
      pd_cnt_d = 4'h0;
      if (!channel_powerdown_n_in || global_powerdown_in) begin
         pd_cnt_d = (pd_cnt_q == 4'hf) ? pd_cnt_q : pd_cnt_q + 4'h1;
      end
      mdc_d = mdc_in;
      idle_cnt_d = (idle_cnt_q == 6'h3f) ? idle_cnt_q : idle_cnt_q + 6'h01;
      if (mdc_in != mdc_q) begin
         idle_cnt_d = 6'h00;
      end
   end
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pd_cnt_q <= 4'h0;
         idle_cnt_q <= 6'h00;
         mdc_q <= 1'b0;
      end else begin
         pd_cnt_q <= pd_cnt_d;
         idle_cnt_q <= idle_cnt_d;
         mdc_q <= mdc_d;
      end
   end
   sequence rst_exit;
      $fell(sys_rst_in);
   endsequence
   // Turnaround: device first drives a zero, then keeps driving
   sequence ta_low;
      !mdio_out && idle_cnt_q < 6'h0c ##1 mdio_oe_out;
   endsequence
   rst_cfg_a: assert property (rst_exit |-> pll_loop_bw_out == 2'h1
      && pll_multiplier_out == 4'h5) else $error("pll config reset value wrong");
   rst_lane_a: assert property (rst_exit |-> output_swing_out == 24'hb6_db6d
      && signal_loss_detect_en_out == 8'hff && deemphasis_level_out == 32'h0000_0000)
      else $error("lane drive reset value wrong");
   rst_rate_a: assert property (rst_exit |-> tx_lane_speed_out == 16'h5555
      && rx_lane_speed_out == 16'h5555) else $error("lane rate reset value wrong");
   pd_pll_a: assert property (pd_cnt_q >= 4'ha |-> !low_side_pll_on_out)
      else $error("pll on during powerdown");
   pd_lane_a: assert property (pd_cnt_q >= 4'ha |-> tx_lane_on_out == 8'h00
      && rx_lane_on_out == 8'h00) else $error("lane on during powerdown");
   pwr_gate_a: assert property ((low_side_pll_on_out || tx_lane_on_out != 8'h00
      || rx_lane_on_out != 8'h00) |-> !$past(global_powerdown_in))
      else $error("enable ignores global powerdown");
   cfg_hold_a: assert property (idle_cnt_q >= 6'h0c |-> $stable(pll_multiplier_out)
      && $stable(pll_loop_bw_out) && $stable(output_swing_out) && $stable(deemphasis_level_out))
      else $error("config changed without a frame");
   ta_drive_a: assert property ($rose(mdio_oe_out) |-> ta_low)
      else $error("bad turnaround drive");
   oe_idle_a: assert property (idle_cnt_q >= 6'h28 |-> !mdio_oe_out)
      else $error("mdio driven while idle");
endmodule
bind lslc_core lslc_core_sva i_lslc_core_sva (.clk_in, .sys_rst_in, .mdc_in, .mdio_out,
   .mdio_oe_out, .channel_powerdown_n_in, .global_powerdown_in, .low_side_pll_on_out,
   .pll_loop_bw_out, .pll_multiplier_out, .output_swing_out, .signal_loss_detect_en_out,
   .tx_lane_on_out, .tx_lane_speed_out, .deemphasis_level_out, .rx_lane_on_out,
   .rx_lane_speed_out);

// ---- sim/lslc_host_model.sv ----
`timescale 1ns/1ps
module lslc_host_model (
   input  wire logic clk_in,
   input  wire logic mdio_in,
   output logic      mdc_out,
   output logic      mdio_drv_out,
   output logic      mdio_en_out
);
   initial begin
      mdc_out = 1'b0;
      mdio_drv_out = 1'b0;
      mdio_en_out = 1'b0;
   end
   // Half an MDC period; 20 clk a bit keeps well above the pin filter's minimum
   task automatic half_bit();
      repeat (10) @(posedge clk_in);
      #1;
   endtask
   // One bit: data set while MDC is low, line seen just before the rise
   task automatic bit_cycle(input logic en, input logic b, output logic seen);
      mdc_out = 1'b0;
      mdio_en_out = en;
      mdio_drv_out = b;
      half_bit();
      seen = mdio_in;
      mdc_out = 1'b1;
      half_bit();
   endtask
   // Whole frame; MDC stands still low afterwards
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, input int npre, output logic [15:0] rd);
      logic [13:0] hdr;
      logic        s;
      hdr = {2'b01, op, phy, ra};
      for (int i = 0; i < npre; i++) bit_cycle(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
      bit_cycle(op == 2'b01, 1'b1, s);
      bit_cycle(op == 2'b01, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cycle(op == 2'b01, wd[i], rd[i]);
      mdc_out = 1'b0;
      mdio_en_out = 1'b0;
      half_bit();
   endtask
endmodule

// ---- sim/low_speed_serdes_lane_config_tb_top.sv ----
`timescale 1ns/1ps
`include "lslc_defines.svh"
`define CHK(NM, EXP, GOT) begin \
   n_tests++; \
   if ((GOT) !== (EXP)) begin \
      error_cnt++; \
      $display("unexpected %s: expected %h seen %h", NM, EXP, GOT); \
   end \
end
module low_speed_serdes_lane_config_tb_top;
   import lslc_pkg::*;
   logic         clk_in, sys_rst_in, mdc, h_drv, h_en, mdio_out, mdio_oe_out;
   logic         channel_powerdown_n_in, global_powerdown_in, low_side_pll_on_out;
   logic [1:0]   pll_loop_bw_out;
   logic [3:0]   pll_multiplier_out;
   logic [7:0]   signal_loss_detect_en_out, tx_lane_on_out, rx_lane_on_out;
   logic [15:0]  tx_lane_speed_out, rx_lane_speed_out;
   logic [23:0]  output_swing_out;
   logic [31:0]  deemphasis_level_out;
   logic [127:0] lane_error_counter_in, lane_signal_loss_count_in, lane_status_word_in;
   lslc_word_t   d;
   int           error_cnt, n_tests, cyc;
   // Pull-up holds the line high when neither side drives
   wire          mdio_w = mdio_oe_out ? mdio_out : (h_en ? h_drv : 1'b1);
   lslc_core #(.PHY_ADDR(5'h03)) i_lslc_core (.clk_in, .sys_rst_in, .mdc_in(mdc),
      .mdio_in(mdio_w), .mdio_out, .mdio_oe_out, .channel_powerdown_n_in, .global_powerdown_in,
      .lane_error_counter_in, .lane_signal_loss_count_in, .lane_status_word_in,
      .low_side_pll_on_out, .pll_loop_bw_out, .pll_multiplier_out, .output_swing_out,
      .signal_loss_detect_en_out, .tx_lane_on_out, .tx_lane_speed_out, .deemphasis_level_out,
      .rx_lane_on_out, .rx_lane_speed_out);
   lslc_host_model i_lslc_host_model (.clk_in, .mdio_in(mdio_w), .mdc_out(mdc),
      .mdio_drv_out(h_drv), .mdio_en_out(h_en));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Frames cost about 1300 clk each; 32 are sent
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 70000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic wr(input logic [4:0] ra, input lslc_word_t wd, input logic [4:0] phy = 5'h03,
                     input int npre = 32);
      lslc_word_t x;
      i_lslc_host_model.frame(2'b01, phy, ra, wd, npre, x);
      repeat (6) @(posedge clk_in);
      #1; // Look at outputs and drive again only once the edge has settled
   endtask
   task automatic rd(input logic [4:0] ra);
      i_lslc_host_model.frame(2'b10, 5'h03, ra, 16'h0000, 32, d);
   endtask
   task automatic t_reset();
      `CHK("pll_on", 1'b1, low_side_pll_on_out)
      `CHK("tx_on", 8'hff, tx_lane_on_out)
      `CHK("rx_on", 8'hff, rx_lane_on_out)
      rd(`LSLC_ADDR_PLL_SEL);
      `CHK("pll_sel", 16'h8115, d)
      rd(`LSLC_ADDR_DRIVE);
      `CHK("drive", 16'hdd05, d)
   endtask
   // Broadcast write with reserved bits set
   task automatic t_bcast();
      wr(`LSLC_ADDR_DRIVE, 16'hc6e9);
      `CHK("swing", {8{3'b100}}, output_swing_out)
      `CHK("los_en", 8'h00, signal_loss_detect_en_out)
      `CHK("tx_speed", {8{2'b10}}, tx_lane_speed_out)
      `CHK("deemph", {8{4'he}}, deemphasis_level_out)
      `CHK("rx_on", 8'h00, rx_lane_on_out)
      rd(`LSLC_ADDR_DRIVE);
      `CHK("drive", 16'hc6e9, d)
   endtask
   // Single-lane write to lane 5 with a reserved rate code
   task automatic t_lane();
      logic [23:0] sw;
      logic [15:0] rs;
      wr(`LSLC_ADDR_PLL_SEL, 16'h5eae);
      `CHK("pll_on", 1'b0, low_side_pll_on_out)
      `CHK("bw", 2'h2, pll_loop_bw_out)
      `CHK("mpy", 4'he, pll_multiplier_out)
      wr(`LSLC_ADDR_DRIVE, 16'h1d07);
      sw = {8{3'b100}};
      sw[15 +: 3] = 3'b001;
      rs = 16'h5555;
      rs[10 +: 2] = 2'b11;
      `CHK("swing", sw, output_swing_out)
      `CHK("rx_speed", rs, rx_lane_speed_out)
      rd(`LSLC_ADDR_PLL_SEL);
      `CHK("pll_sel", 16'h5eae, d)
      rd(`LSLC_ADDR_DRIVE);
      `CHK("drive", 16'h1d07, d)
   endtask
   // Every selector code steers one of the status reads
   task automatic t_sel();
      for (int l = 0; l < 8; l++) begin
         wr(`LSLC_ADDR_PLL_SEL, {1'b0, l[2:0], 12'h115});
         rd(5'(`LSLC_ADDR_ERR_CNT + l % 3));
         `CHK("lane_stat", 16'(16'ha000 + 16'h1000 * (l % 3) + l), d)
      end
   endtask
   task automatic t_pd();
      wr(`LSLC_ADDR_PLL_SEL, 16'h8115);
      `CHK("rx_on", 8'h20, rx_lane_on_out)
      channel_powerdown_n_in = 1'b0;
      repeat (12) @(posedge clk_in);
      #1;
      `CHK("pll_on", 1'b0, low_side_pll_on_out)
      `CHK("tx_on", 8'h00, tx_lane_on_out)
      channel_powerdown_n_in = 1'b1;
      repeat (12) @(posedge clk_in);
      #1;
      `CHK("pll_on", 1'b1, low_side_pll_on_out)
      global_powerdown_in = 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      `CHK("pll_on", 1'b0, low_side_pll_on_out)
      `CHK("rx_on", 8'h00, rx_lane_on_out)
      global_powerdown_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      `CHK("tx_on", 8'hff, tx_lane_on_out)
   endtask
   // Frames that must be ignored
   task automatic t_refuse();
      wr(`LSLC_ADDR_DRIVE, 16'h0000, 5'h04);
      wr(`LSLC_ADDR_DRIVE, 16'h0000, 5'h03, 31);
      wr(`LSLC_ADDR_ERR_CNT, 16'h0000);
      wr(5'h1f, 16'hffff);
      rd(5'h1f);
      `CHK("unmapped", 16'h0000, d)
      rd(`LSLC_ADDR_ERR_CNT);
      `CHK("err_cnt", 16'ha000, d)
      rd(`LSLC_ADDR_DRIVE);
      `CHK("drive", 16'hc6e9, d)
   endtask
   initial begin
      error_cnt = 0;
      n_tests = 0;
      cyc = 0;
      sys_rst_in = 1'b1;
      channel_powerdown_n_in = 1'b1;
      global_powerdown_in = 1'b0;
      for (int l = 0; l < 8; l++) begin
         lane_error_counter_in[16*l +: 16] = 16'ha000 + 16'(l);
         lane_signal_loss_count_in[16*l +: 16] = 16'hb000 + 16'(l);
         lane_status_word_in[16*l +: 16] = 16'hc000 + 16'(l);
      end
      repeat (3) @(posedge clk_in);
      #1;
      sys_rst_in = 1'b0;
      repeat (10) @(posedge clk_in);
      #1;
      t_reset();
      t_bcast();
      t_lane();
      t_sel();
      t_pd();
      t_refuse();
      print_verdict();
   end
endmodule
